// >>> rtl/bil_pkg.sv
// Constants, field values and state types of the boot image loader.
// Assumes a single 100 MHz core clock, byte-wide link tokens and 32-bit OTP words.
package bil_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned BIL_CLK_MHZ = 100;
  localparam int unsigned BIL_RESET_WAIT_CLOCKS = 750000;
  localparam int unsigned BIL_LINK_EN_DELAY_NS = 200;
  // Least time, rounded up to whole cycles
  localparam int unsigned BIL_LINK_EN_DELAY_CYC =
    (BIL_LINK_EN_DELAY_NS * BIL_CLK_MHZ + 999) / 1000;
  localparam int unsigned BIL_SPI_SCLK_KHZ = 2500;
  // Half period of the serial clock in core cycles
  localparam int unsigned BIL_SPI_HALF_CYC =
    (BIL_CLK_MHZ * 1000) / (2 * BIL_SPI_SCLK_KHZ);

  // ****************************************************************
  // Image format and checking
  // ****************************************************************
  localparam logic [31:0] BIL_CRC_BYPASS = 32'h0D15AB1E;
  localparam logic [31:0] BIL_CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] BIL_CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] BIL_NULL_CHANEND = 32'h0000FF02;
  localparam logic [7:0] BIL_CT_END = 8'h01;
  localparam logic [15:0] BIL_RAM_BASE = 16'h0000;
  localparam logic [10:0] BIL_OTP_BASE = 11'h000;
  localparam int unsigned BIL_SECURE_BOOT_BIT = 5;

  // ****************************************************************
  // Serial flash
  // ****************************************************************
  localparam logic [7:0] BIL_SPI_READ_CMD = 8'h03;
  localparam logic [23:0] BIL_SPI_START_ADDR = 24'h000000;

  // ****************************************************************
  // Straps and PLL fields
  // ****************************************************************
  localparam logic [2:0] BIL_STRAP_LINK = 3'h2;
  localparam logic [2:0] BIL_STRAP_SPI = 3'h3;
  localparam logic [2:0] BIL_STRAP_LINK_ALL = 3'h6;
  localparam logic [2:0] BIL_STRAP_SPI_ALL = 3'h7;
  localparam logic [2:0] BIL_PLL_OD_R00 = 3'h1;
  localparam logic [11:0] BIL_PLL_F_R00 = 12'h07A;
  localparam logic [2:0] BIL_PLL_OD_R11 = 3'h2;
  localparam logic [11:0] BIL_PLL_F_R11 = 12'h077;
  localparam logic [2:0] BIL_PLL_OD_R10 = 3'h2;
  localparam logic [11:0] BIL_PLL_F_R10 = 12'h031;
  localparam logic [2:0] BIL_PLL_OD_R01 = 3'h2;
  localparam logic [11:0] BIL_PLL_F_R01 = 12'h017;
  localparam logic [5:0] BIL_PLL_R_ALL = 6'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    BIL_ST_WAIT = 4'h0, BIL_ST_DECODE = 4'h1, BIL_ST_JTAG = 4'h2,
    BIL_ST_RSVD = 4'h3, BIL_ST_LINK_DLY = 4'h4, BIL_ST_LOAD = 4'h5,
    BIL_ST_END_RX = 4'h6, BIL_ST_END_TX = 4'h7, BIL_ST_CHECK = 4'h8,
    BIL_ST_JUMP = 4'h9, BIL_ST_RUN = 4'hA, BIL_ST_FAIL = 4'hB
  } bil_state_type;

  typedef enum logic [2:0] {
    BIL_SRC_NONE = 3'h0, BIL_SRC_RSVD = 3'h1, BIL_SRC_LINK = 3'h2,
    BIL_SRC_SPI = 3'h3, BIL_SRC_OTP = 3'h4
  } bil_src_type;

  typedef enum logic [2:0] {
    BIL_P_ACK = 3'h0, BIL_P_LEN = 3'h1, BIL_P_PROG = 3'h2,
    BIL_P_CRC = 3'h3, BIL_P_DONE = 3'h4
  } bil_parse_type;

endpackage : bil_pkg

// >>> rtl/bil_loader.sv
// Boot image loader: reset wait, source decode, image fetch and check.
// Assumes synchronous straps and pins, and byte-writable RAM behind it.
`timescale 1ns/1ps
`default_nettype none

module bil_loader
  import bil_pkg::*;
#(
  parameter int unsigned RESET_WAIT_CLOCKS = BIL_RESET_WAIT_CLOCKS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_boot_src_strap,
  input wire logic i_pll_ratio_strap_lo,
  input wire logic i_pll_ratio_strap_hi,
  input wire logic [31:0] i_security_cfg,
  output logic o_gpio_hiz,
  output logic o_gpio_pull_en,
  output logic [2:0] o_pll_output_divider,
  output logic [11:0] o_pll_feedback_mul,
  output logic [5:0] o_pll_ref_div,
  output logic o_spi_oe,
  output logic o_spi_sclk,
  output logic o_spi_sel_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso,
  output logic o_link_out_wire_a,
  output logic o_link_out_wire_b,
  output logic o_link_out_oe,
  output logic o_link_pulldown_en,
  input wire logic i_link_in_wire_a,
  input wire logic i_link_in_wire_b,
  output logic o_chanend0_alloc,
  input wire logic i_tok_rx_valid,
  input wire logic i_tok_rx_ctrl,
  input wire logic [7:0] i_tok_rx_data,
  output logic o_tok_rx_ready,
  output logic o_tok_tx_valid,
  output logic o_tok_tx_ctrl,
  output logic [7:0] o_tok_tx_data,
  output logic [31:0] o_tok_tx_dest,
  input wire logic i_tok_tx_ready,
  output logic o_otp_rd,
  output logic [10:0] o_otp_addr,
  input wire logic i_otp_valid,
  input wire logic [31:0] i_otp_data,
  output logic o_ram_we,
  output logic [15:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  output logic o_jump,
  output logic [15:0] o_exec_addr,
  output logic [2:0] o_boot_src,
  output logic o_jtag_wait,
  output logic o_boot_fail,
  output logic o_boot_done
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Reflected CRC of one byte, bit 0 first
  function automatic logic [31:0] bil_crc_byte(input logic [31:0] c,
                                               input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : bil_crc_byte

  // Strap decode; secure boot wins over the straps
  function automatic bil_src_type bil_decode(input logic [2:0] s,
                                             input logic sec);
    if (sec) begin
      return BIL_SRC_OTP;
    end
    if (s[1:0] == 2'b00) begin
      return BIL_SRC_NONE;
    end
    if (s[1:0] == 2'b01) begin
      return BIL_SRC_RSVD;
    end
    if ((s == BIL_STRAP_LINK) || (s == BIL_STRAP_LINK_ALL)) begin
      return BIL_SRC_LINK;
    end
    return BIL_SRC_SPI;
  endfunction : bil_decode

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bil_state_type state_q;
  bil_src_type src_q;
  bil_parse_type ps_q;
  logic [19:0] wait_cnt_q;
  logic [4:0] dly_cnt_q;
  logic [1:0] bcnt_q;
  logic [31:0] word_sh_q;
  logic [31:0] words_left_q;
  logic [31:0] crc_q;
  logic [31:0] chk_q;
  logic [31:0] ack_dest_q;
  logic [15:0] ram_addr_q;
  logic link_en_q;
  logic strap_cap_q;
  logic spi_active_q;
  logic spi_sclk_q;
  logic [4:0] spi_half_q;
  logic [31:0] spi_hdr_q;
  logic [5:0] spi_hdr_cnt_q;
  logic [2:0] spi_bit_q;
  logic [7:0] spi_rx_q;
  logic spi_byte_v_q;
  logic [7:0] spi_byte_q;
  logic spi_sel_n_q;
  logic spi_mosi_q;
  logic otp_pend_q;
  logic [2:0] otp_left_q;
  logic [31:0] otp_word_q;
  logic byte_v;
  logic [7:0] byte_d;
  logic [31:0] new_word;
  logic loading;
  logic spi_edge;

  assign loading = (state_q == BIL_ST_LOAD);
  assign spi_edge = (spi_half_q == 5'(BIL_SPI_HALF_CYC - 1));
  assign new_word = {byte_d, word_sh_q[31:8]};

  // Token receive ready only while a byte or END is expected
  // Low once the check word is in, so END is never taken as image data
  assign o_tok_rx_ready = (loading && (src_q == BIL_SRC_LINK)
                           && (ps_q != BIL_P_DONE))
                          || (state_q == BIL_ST_END_RX);

  // Byte source selection for the common image parser
  always_comb begin
    unique case (src_q)
      BIL_SRC_SPI: begin
        byte_v = spi_byte_v_q && loading;
        byte_d = spi_byte_q;
      end
      BIL_SRC_LINK: begin
        byte_v = loading && i_tok_rx_valid && !i_tok_rx_ctrl;
        byte_d = i_tok_rx_data;
      end
      BIL_SRC_OTP: begin
        byte_v = loading && (otp_left_q != 3'h0);
        byte_d = otp_word_q[7:0];
      end
      default: begin
        byte_v = 1'b0;
        byte_d = 8'h00;
      end
    endcase
  end

  // ****************************************************************
  // Reset wait and pin state
  // ****************************************************************
  // Pins float in reset; pulls only come on once the wait has run
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_cnt_q <= 20'h00000;
      o_gpio_hiz <= 1'b1;
      o_gpio_pull_en <= 1'b0;
    end else if (state_q == BIL_ST_WAIT) begin
      wait_cnt_q <= wait_cnt_q + 20'h00001;
      if (wait_cnt_q == 20'(RESET_WAIT_CLOCKS - 1)) begin
        o_gpio_hiz <= 1'b0;
        o_gpio_pull_en <= 1'b1;
      end
    end
  end

  // Ratio straps caught once after release; they must then stay put
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_cap_q <= 1'b0;
      o_pll_output_divider <= BIL_PLL_OD_R00;
      o_pll_feedback_mul <= BIL_PLL_F_R00;
      o_pll_ref_div <= BIL_PLL_R_ALL;
    end else if (!strap_cap_q) begin
      strap_cap_q <= 1'b1;
      o_pll_ref_div <= BIL_PLL_R_ALL;
      unique case ({i_pll_ratio_strap_hi, i_pll_ratio_strap_lo})
        2'b00: begin
          o_pll_output_divider <= BIL_PLL_OD_R00;
          o_pll_feedback_mul <= BIL_PLL_F_R00;
        end
        2'b11: begin
          o_pll_output_divider <= BIL_PLL_OD_R11;
          o_pll_feedback_mul <= BIL_PLL_F_R11;
        end
        2'b10: begin
          o_pll_output_divider <= BIL_PLL_OD_R10;
          o_pll_feedback_mul <= BIL_PLL_F_R10;
        end
        2'b01: begin
          o_pll_output_divider <= BIL_PLL_OD_R01;
          o_pll_feedback_mul <= BIL_PLL_F_R01;
        end
      endcase
    end
  end

  // ****************************************************************
  // Main sequencer
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= BIL_ST_WAIT;
      src_q <= BIL_SRC_NONE;
      dly_cnt_q <= 5'h00;
      link_en_q <= 1'b0;
      o_chanend0_alloc <= 1'b0;
      o_tok_tx_valid <= 1'b0;
      o_jump <= 1'b0;
    end else begin
      o_jump <= 1'b0;
      unique case (state_q)
        BIL_ST_WAIT: begin
          if (wait_cnt_q == 20'(RESET_WAIT_CLOCKS - 1)) begin
            state_q <= BIL_ST_DECODE;
          end
        end
        BIL_ST_DECODE: begin
          src_q <= bil_decode(i_boot_src_strap,
                              i_security_cfg[BIL_SECURE_BOOT_BIT]);
          unique case (bil_decode(i_boot_src_strap,
                                  i_security_cfg[BIL_SECURE_BOOT_BIT]))
            BIL_SRC_NONE: state_q <= BIL_ST_JTAG;
            BIL_SRC_RSVD: state_q <= BIL_ST_RSVD;
            BIL_SRC_LINK: state_q <= BIL_ST_LINK_DLY;
            default: state_q <= BIL_ST_LOAD;
          endcase
        end
        BIL_ST_LINK_DLY: begin
          // Link comes up after the delay; inbound wires must read low
          if (dly_cnt_q != 5'(BIL_LINK_EN_DELAY_CYC - 1)) begin
            dly_cnt_q <= dly_cnt_q + 5'h01;
          end else begin
            link_en_q <= 1'b1;
            o_chanend0_alloc <= 1'b1;
            if (link_en_q && !i_link_in_wire_a && !i_link_in_wire_b) begin
              state_q <= BIL_ST_LOAD;
            end
          end
        end
        BIL_ST_LOAD: begin
          if (o_tok_rx_ready && i_tok_rx_valid && i_tok_rx_ctrl) begin
            state_q <= BIL_ST_FAIL; // Control token inside image
          end else if (ps_q == BIL_P_DONE) begin
            state_q <= (src_q == BIL_SRC_LINK) ? BIL_ST_END_RX
                                               : BIL_ST_CHECK;
          end
        end
        BIL_ST_END_RX: begin
          if (i_tok_rx_valid) begin
            if (i_tok_rx_ctrl && (i_tok_rx_data == BIL_CT_END)) begin
              if (ack_dest_q == BIL_NULL_CHANEND) begin
                state_q <= BIL_ST_CHECK;
                o_chanend0_alloc <= 1'b0;
              end else begin
                state_q <= BIL_ST_END_TX;
                o_tok_tx_valid <= 1'b1;
              end
            end else begin
              state_q <= BIL_ST_FAIL;
            end
          end
        end
        BIL_ST_END_TX: begin
          if (i_tok_tx_ready) begin
            o_tok_tx_valid <= 1'b0;
            o_chanend0_alloc <= 1'b0;
            state_q <= BIL_ST_CHECK;
          end
        end
        BIL_ST_CHECK: begin
          if ((chk_q == BIL_CRC_BYPASS) || (chk_q == ~crc_q)) begin
            state_q <= BIL_ST_JUMP;
          end else begin
            state_q <= BIL_ST_FAIL;
          end
        end
        BIL_ST_JUMP: begin
          o_jump <= 1'b1;
          state_q <= BIL_ST_RUN;
        end
        BIL_ST_JTAG, BIL_ST_RSVD, BIL_ST_RUN, BIL_ST_FAIL: begin
          state_q <= state_q; // Held until the next reset
        end
        default: state_q <= BIL_ST_FAIL;
      endcase
    end
  end

  // ****************************************************************
  // Image parser, CRC and RAM write
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ps_q <= BIL_P_LEN;
      bcnt_q <= 2'h0;
      word_sh_q <= 32'h00000000;
      words_left_q <= 32'h00000000;
      crc_q <= BIL_CRC_INIT;
      chk_q <= 32'h00000000;
      ack_dest_q <= BIL_NULL_CHANEND;
      ram_addr_q <= BIL_RAM_BASE;
      o_ram_we <= 1'b0;
      o_ram_addr <= BIL_RAM_BASE;
      o_ram_wdata <= 8'h00;
    end else begin
      o_ram_we <= 1'b0;
      if (state_q == BIL_ST_DECODE) begin
        // Link images open with the acknowledge destination word
        ps_q <= (bil_decode(i_boot_src_strap,
                            i_security_cfg[BIL_SECURE_BOOT_BIT])
                 == BIL_SRC_LINK) ? BIL_P_ACK : BIL_P_LEN;
      end else if (byte_v && (ps_q != BIL_P_DONE)) begin
        bcnt_q <= bcnt_q + 2'h1;
        word_sh_q <= new_word;
        unique case (ps_q)
          BIL_P_ACK: begin
            if (bcnt_q == 2'h3) begin
              ack_dest_q <= new_word;
              ps_q <= BIL_P_LEN;
            end
          end
          BIL_P_LEN: begin
            crc_q <= bil_crc_byte(crc_q, byte_d);
            if (bcnt_q == 2'h3) begin
              words_left_q <= new_word;
              ps_q <= (new_word == 32'h00000000) ? BIL_P_CRC : BIL_P_PROG;
            end
          end
          BIL_P_PROG: begin
            crc_q <= bil_crc_byte(crc_q, byte_d);
            o_ram_we <= 1'b1;
            o_ram_addr <= ram_addr_q;
            o_ram_wdata <= byte_d;
            ram_addr_q <= ram_addr_q + 16'h0001;
            if (bcnt_q == 2'h3) begin
              words_left_q <= words_left_q - 32'h00000001;
              if (words_left_q == 32'h00000001) begin
                ps_q <= BIL_P_CRC;
              end
            end
          end
          BIL_P_CRC: begin
            if (bcnt_q == 2'h3) begin
              chk_q <= new_word;
              ps_q <= BIL_P_DONE;
            end
          end
          default: ps_q <= BIL_P_DONE;
        endcase
      end
    end
  end

  // ****************************************************************
  // SPI master, mode 0
  // ****************************************************************
  // Header goes out MSB first as flash parts expect; data comes in LSB
  // first, so the stored image must be bit-reversed per byte if needed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      spi_active_q <= 1'b0;
      spi_sclk_q <= 1'b0;
      spi_half_q <= 5'h00;
      spi_hdr_q <= 32'h00000000;
      spi_hdr_cnt_q <= 6'h00;
      spi_bit_q <= 3'h0;
      spi_rx_q <= 8'h00;
      spi_byte_v_q <= 1'b0;
      spi_byte_q <= 8'h00;
      spi_sel_n_q <= 1'b1;
      spi_mosi_q <= 1'b0;
    end else begin
      spi_byte_v_q <= 1'b0;
      if (!loading || (ps_q == BIL_P_DONE)) begin
        spi_sel_n_q <= 1'b1;
        spi_sclk_q <= 1'b0;
      end else if ((src_q == BIL_SRC_SPI) && !spi_active_q) begin
        spi_active_q <= 1'b1;
        spi_sel_n_q <= 1'b0;
        spi_hdr_q <= {BIL_SPI_READ_CMD, BIL_SPI_START_ADDR};
        spi_mosi_q <= BIL_SPI_READ_CMD[7];
        spi_hdr_cnt_q <= 6'h20;
        spi_half_q <= 5'h00;
      end else if (spi_active_q) begin
        spi_half_q <= spi_edge ? 5'h00 : spi_half_q + 5'h01;
        if (spi_edge) begin
          spi_sclk_q <= !spi_sclk_q;
          if (!spi_sclk_q && (spi_hdr_cnt_q == 6'h00)) begin
            // Rising edge samples, LSB first
            spi_rx_q <= {i_spi_miso, spi_rx_q[7:1]};
            spi_bit_q <= spi_bit_q + 3'h1;
            if (spi_bit_q == 3'h7) begin
              spi_byte_v_q <= 1'b1;
              spi_byte_q <= {i_spi_miso, spi_rx_q[7:1]};
            end
          end else if (spi_sclk_q && (spi_hdr_cnt_q != 6'h00)) begin
            // Falling edge presents the next header bit
            spi_hdr_cnt_q <= spi_hdr_cnt_q - 6'h01;
            spi_hdr_q <= {spi_hdr_q[30:0], 1'b0};
            spi_mosi_q <= spi_hdr_q[30];
          end
        end
      end
    end
  end

  assign o_spi_oe = (src_q == BIL_SRC_SPI) && !o_gpio_hiz;
  assign o_spi_sclk = spi_sclk_q;
  assign o_spi_sel_n = spi_sel_n_q;
  assign o_spi_mosi = spi_mosi_q;

  // ****************************************************************
  // OTP reader
  // ****************************************************************
  // One word in flight; each word unpacks to four bytes, low byte first
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_otp_rd <= 1'b0;
      o_otp_addr <= BIL_OTP_BASE;
      otp_pend_q <= 1'b0;
      otp_left_q <= 3'h0;
      otp_word_q <= 32'h00000000;
    end else begin
      o_otp_rd <= 1'b0;
      if (i_otp_valid && otp_pend_q) begin
        otp_pend_q <= 1'b0;
        otp_word_q <= i_otp_data;
        otp_left_q <= 3'h4;
        o_otp_addr <= o_otp_addr + 11'h001;
      end else if (otp_left_q != 3'h0) begin
        otp_word_q <= {8'h00, otp_word_q[31:8]};
        otp_left_q <= otp_left_q - 3'h1;
      end else if (loading && (src_q == BIL_SRC_OTP) && !otp_pend_q
                   && (ps_q != BIL_P_DONE)) begin
        o_otp_rd <= 1'b1;
        otp_pend_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Link pins, tokens and status
  // ****************************************************************
  assign o_link_out_wire_a = 1'b0;
  assign o_link_out_wire_b = 1'b0;
  assign o_link_out_oe = link_en_q;
  assign o_link_pulldown_en = o_gpio_pull_en && !link_en_q;
  assign o_tok_tx_ctrl = 1'b1;
  assign o_tok_tx_data = BIL_CT_END;
  assign o_tok_tx_dest = ack_dest_q;
  assign o_exec_addr = BIL_RAM_BASE;
  assign o_boot_src = src_q;
  assign o_jtag_wait = (state_q == BIL_ST_JTAG);
  assign o_boot_fail = (state_q == BIL_ST_FAIL);
  assign o_boot_done = (state_q == BIL_ST_RUN);

endmodule : bil_loader

`default_nettype wire

// >>> verification/bil_sva.sv
// Checker: timing relations at the boot loader's ports.
// Assumes one clock domain; bound to every loader instance.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module bil_sva
  import bil_pkg::*;
#(parameter int unsigned RESET_WAIT_CLOCKS = 10) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic o_gpio_hiz,
  input wire logic o_gpio_pull_en,
  input wire logic o_spi_oe,
  input wire logic o_spi_sclk,
  input wire logic o_spi_sel_n,
  input wire logic o_spi_mosi,
  input wire logic o_link_out_oe,
  input wire logic o_link_pulldown_en,
  input wire logic o_link_out_wire_a,
  input wire logic o_link_out_wire_b,
  input wire logic o_jump,
  input wire logic [15:0] o_exec_addr,
  input wire logic o_boot_fail,
  input wire logic o_boot_done
);
  logic [31:0] wait_q;
  // Edges since release, saturating so long runs cannot wrap
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn) wait_q <= '0;
    else if (wait_q != '1) wait_q <= wait_q + 32'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  pull_hiz_a: assert property (o_gpio_pull_en != o_gpio_hiz)
    else $error("pull and hiz overlap");
  wait_len_a: assert property ($fell(o_gpio_hiz) |->
    wait_q == RESET_WAIT_CLOCKS) else $error("reset wait length wrong");
  sclk_idle_a: assert property (o_spi_sel_n |-> !o_spi_sclk)
    else $error("serial clock not idle low");
  sclk_high_a: assert property ($fell(o_spi_sclk) && !o_spi_sel_n |->
    $past(o_spi_sclk, 20) && !$past(o_spi_sclk, 21))
    else $error("serial clock high phase wrong");
  cmd_first_a: assert property ($fell(o_spi_sel_n) |-> o_spi_oe &&
    o_spi_mosi == BIL_SPI_READ_CMD[7] && !o_spi_sclk)
    else $error("read command start wrong");
  link_idle_a: assert property (o_link_out_oe |-> !o_link_pulldown_en &&
    !o_link_out_wire_a && !o_link_out_wire_b) else $error("link pins wrong");
  jump_once_a: assert property (o_jump |-> o_exec_addr == 16'h0000 ##1
    !o_jump ##[0:1] o_boot_done) else $error("jump not single");
  fail_stay_a: assert property (o_boot_fail |=> o_boot_fail && !o_jump)
    else $error("failed boot left");
  c_jump: cover property (o_jump);
  c_fail: cover property (o_boot_fail);
  c_link: cover property ($rose(o_link_out_oe));
endmodule : bil_sva
bind bil_loader bil_sva #(.RESET_WAIT_CLOCKS(RESET_WAIT_CLOCKS)) bil_sva_inst (.*);
`default_nettype wire

// >>> verification/bil_flash.sv
// Serial flash model: answers one read from address zero.
// Assumes mode 0 clocking and a byte array preloaded by the bench.
`timescale 1ns/1ps
`default_nettype none
// ****
// Flash
// ****
module bil_flash
  import bil_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  output logic o_miso
);
  logic [7:0] mem [0:63];
  logic [31:0] hdr_q;
  int bits = 0;
  initial o_miso = 1'b0;
  // Header shifts in on rising clock while selected
  always @(negedge i_sel_n) bits = 0;
  always @(posedge i_sclk) if (!i_sel_n) begin
    if (bits < 32) hdr_q = {hdr_q[30:0], i_mosi};
    bits++;
  end
  // Data moves on falling clock; a wrong header gets inverted data
  always @(negedge i_sclk or posedge i_sel_n)
    if (i_sel_n) o_miso <= ~o_miso;
    else if (bits >= 32) o_miso <= mem[(bits-32)/8][(bits-32)%8] ^
      (hdr_q != {BIL_SPI_READ_CMD, 24'h000000});
endmodule : bil_flash
`default_nettype wire

// >>> verification/testbench.sv
// Bench: boots the loader from each source and checks RAM and status.
// Assumes the flash model and a reset wait shortened to W clocks.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module testbench;
  import bil_pkg::*;
  localparam int W = 10;
  logic i_clk = 0, i_rstn = 0, i_pll_ratio_strap_lo = 0, i_spi_miso;
  logic i_pll_ratio_strap_hi = 0, i_tok_rx_valid = 0, i_otp_valid = 0;
  logic i_link_in_wire_a = 0, i_link_in_wire_b = 0;
  logic i_tok_rx_ctrl = 0, i_tok_tx_ready = 1;
  logic [2:0] i_boot_src_strap = 0, o_pll_output_divider, o_boot_src;
  logic [31:0] i_security_cfg = 0, i_otp_data = 0, o_tok_tx_dest;
  logic [7:0] i_tok_rx_data = 0, o_tok_tx_data, o_ram_wdata;
  logic [11:0] o_pll_feedback_mul;
  logic [5:0] o_pll_ref_div;
  logic [10:0] o_otp_addr;
  logic [15:0] o_ram_addr, o_exec_addr;
  logic o_gpio_hiz, o_gpio_pull_en, o_spi_oe, o_spi_sclk, o_spi_sel_n;
  logic o_spi_mosi, o_link_out_wire_a, o_link_out_wire_b, o_link_out_oe;
  logic o_link_pulldown_en, o_chanend0_alloc, o_tok_rx_ready, o_jump;
  logic o_tok_tx_valid, o_tok_tx_ctrl, o_otp_rd, o_ram_we, o_jtag_wait;
  logic o_boot_fail, o_boot_done;
  logic [7:0] img[$];
  logic [23:0] exp_q[$];
  int error_cnt = 0, cmp_count = 0, seed = 44, txn = 0;
  logic [31:0] ack;
  // Case: strap, secure bit, ratio straps, check kind (good/bad/bypass)
  logic [7:0] cases [8] = '{8'h60, 8'hE5, 8'h52, 8'hCC, 8'h70, 8'h84, 8'h28,
    8'h40};
  // Divider, multiplier, reference fields by {hi, lo}
  logic [20:0] pll_t [4] = '{21'h41E80, 21'h805C0, 21'h80C40, 21'h81DC0};
  always #5 i_clk = ~i_clk;
  bil_loader #(.RESET_WAIT_CLOCKS(W)) bil_loader_inst (.*);
  bil_flash bil_flash_inst (.i_sclk(o_spi_sclk), .i_sel_n(o_spi_sel_n),
    .i_mosi(o_spi_mosi), .o_miso(i_spi_miso));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic to(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("mismatch at %0t: wait %h limit %h", $time, n, lim);
      conclude;
    end
  endtask : to
  // One token, held until the loader takes it
  task automatic tok(input logic c, input logic [7:0] d);
    int n;
    i_tok_rx_valid <= 1'b1;
    i_tok_rx_ctrl <= c;
    i_tok_rx_data <= d;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_tok_rx_ready !== 1'b1 && n < 5000);
    to(n, 5000);
    @(posedge i_clk);
  endtask : tok
  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] r;
    r = BIL_CRC_INIT;
    foreach (b[i]) begin
      r ^= {24'h0, b[i]};
      repeat (8) r = r[0] ? (r >> 1) ^ BIL_CRC_POLY : r >> 1;
    end
    return ~r;
  endfunction : crc
  // OTP stand-in: answers each read next cycle with the addressed word
  always @(posedge i_clk) begin
    i_otp_valid <= o_otp_rd;
    if (o_otp_rd === 1'b1) i_otp_data <= {img[o_otp_addr*4+3], img[o_otp_addr*4+2],
      img[o_otp_addr*4+1], img[o_otp_addr*4]};
  end
  // Each RAM write takes the oldest expected address and byte
  always @(posedge i_clk) if (o_ram_we === 1'b1) begin
    chk({o_ram_addr, o_ram_wdata}, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // Each END sent back goes to the host's word while chanend 0 is held
  always @(posedge i_clk) if (o_tok_tx_valid === 1'b1 && i_tok_tx_ready) begin
    txn++;
    chk(o_tok_tx_dest, ack);
    chk({o_tok_tx_ctrl, o_tok_tx_data, o_chanend0_alloc},
      {1'b1, BIL_CT_END, 1'b1});
  end
  initial begin
    logic [7:0] c;
    logic [31:0] len, w;
    logic [2:0] src;
    int n;
    foreach (cases[k]) begin
      c = cases[k];
      i_rstn <= 1'b0;
      i_boot_src_strap <= c[7:5];
      {i_pll_ratio_strap_hi, i_pll_ratio_strap_lo} <= c[3:2];
      i_security_cfg <= $random(seed) & ~32'h20 | {26'h0, c[4], 5'h0};
      img = {};
      exp_q = {};
      txn = 0;
      ack = c[7] ? BIL_NULL_CHANEND : $random(seed);
      len = $unsigned($random(seed)) % 3;
      for (int i = 0; i < 4; i++) img.push_back(len[i*8 +: 8]);
      for (int i = 0; i < len * 4; i++) begin
        img.push_back(8'($random(seed)));
        exp_q.push_back({i[15:0], img[$]});
      end
      w = c[1:0] == 2'h2 ? BIL_CRC_BYPASS : crc(img) ^ {32{c[0]}};
      for (int i = 0; i < 4; i++) img.push_back(w[i*8 +: 8]);
      foreach (img[i]) bil_flash_inst.mem[i] = img[i];
      src = c[4] ? 3'h4 : {1'b0, c[6:5]};
      if (src < 3'h2) exp_q = {};
      repeat (3) @(posedge i_clk);
      chk(o_gpio_hiz, 1);
      i_rstn <= 1'b1;
      repeat (W + 3) @(posedge i_clk);
      chk({o_pll_output_divider, o_pll_feedback_mul, o_pll_ref_div},
        pll_t[c[3:2]]);
      chk(o_boot_src, src);
      if (src == 3'h2) begin
        for (int i = 0; i < 4; i++) tok(0, ack[i*8 +: 8]);
        foreach (img[i]) tok(0, img[i]);
        tok(1, BIL_CT_END);
        i_tok_rx_valid <= 1'b0;
      end
      n = 0;
      while (src > 1 && (o_boot_done | o_boot_fail) !== 1'b1 && n < 20000) begin
        @(posedge i_clk);
        n++;
      end
      to(n, 20000);
      repeat (4) @(posedge i_clk);
      chk({o_boot_done, o_boot_fail, o_jtag_wait}, src < 2 ? {2'b0, src == 0}
        : c[1:0] == 2'h1 ? 3'b010 : 3'b100);
      chk(exp_q.size(), 0);
      chk(txn, src == 3'h2 && !c[7]);
      $display("test %0d done", k);
    end
    conclude;
  end
endmodule : testbench
`default_nettype wire
